// file: rtl/vsfs_pkg.sv
// constants for the video serializer multi-function i/o select block
// assumes one 40 MHz clock and a synchronous active-high reset
//
// Contract
// - six-bit pattern select word; bit 5 low selects standard definition
// - sd word: bit4 ntsc/pal, bits3..2 rate, bits1..0 pattern
// - sd self-test uses only ntsc 4x3 bars and pal 4x3 pll pattern
// - hd self-test uses color bars of the selected raster format
// - each pin takes one six-bit function; bit5 low output, high input
// - output codes 0x15-0x1F carry format, fifo, lock, test and checksum
// - input codes 0x20-0x2F drive control bits and pattern select bits
// - after reset pins carry f, v, h, format4, lock, edh, pass, generator enable
package vsfs_pkg;

  localparam int          NUM_PINS   = 8;
  localparam int          CODE_W     = 6;
  localparam int          REG_ADDR_W = 4;
  localparam int          DATA_W     = 8;

  // function codes
  localparam logic [5:0] FN_FF_ERR     = 6'h01;
  localparam logic [5:0] FN_PKT_ERR    = 6'h02;
  localparam logic [5:0] FN_ANC_ERR    = 6'h03;
  localparam logic [5:0] FN_EDH_ERR    = 6'h04;
  localparam logic [5:0] FN_SAV        = 6'h0D;
  localparam logic [5:0] FN_EAV        = 6'h0E;
  localparam logic [5:0] FN_PROT       = 6'h0F;
  localparam logic [5:0] FN_FIELD      = 6'h12;
  localparam logic [5:0] FN_VBLANK     = 6'h13;
  localparam logic [5:0] FN_HBLANK     = 6'h14;
  localparam logic [5:0] FN_FORMAT0    = 6'h15;
  localparam logic [5:0] FN_FORMAT4    = 6'h19;
  localparam logic [5:0] FN_FIFO_FULL  = 6'h1A;
  localparam logic [5:0] FN_FIFO_EMPTY = 6'h1B;
  localparam logic [5:0] FN_LOCK       = 6'h1C;
  localparam logic [5:0] FN_PASS_FAIL  = 6'h1D;
  localparam logic [5:0] FN_OVERRUN    = 6'h1E;
  localparam logic [5:0] FN_CKSUM_ERR  = 6'h1F;
  localparam logic [5:0] FN_IN_BASE    = 6'h20;
  localparam logic [5:0] FN_PGEN       = 6'h28;

  // which codes are real functions
  localparam logic [31:0] OUT_VALID = 32'hFFFC_E01E;
  localparam logic [15:0] IN_VALID  = 16'hB5FF;

  // input function index, code minus 0x20
  localparam int IN_FORCE  = 0;
  localparam int IN_PAT0   = 1;
  localparam int IN_EDH_EN = 7;
  localparam int IN_PGEN   = 8;
  localparam int IN_CKSUM  = 10;
  localparam int IN_FILTER = 12;
  localparam int IN_DITHER = 13;
  localparam int IN_FINS   = 15;

  // pattern word fields
  localparam int          PAT_HD   = 5;
  localparam int          PAT_PAL  = 4;
  localparam logic [1:0]  RATE_BAD = 2'h3;
  localparam logic [1:0]  PAT_BARS = 2'h3;
  localparam logic [5:0]  BIST_NTSC_BARS = 6'h03;
  localparam logic [5:0]  BIST_PAL_PLL   = 6'h11;

  // power-on pin assignment, pin 7 down to pin 0
  localparam logic [7:0][5:0] PIN_DEFAULT = {
    FN_PGEN, FN_PASS_FAIL, FN_EDH_ERR, FN_LOCK,
    FN_FORMAT4, FN_HBLANK, FN_VBLANK, FN_FIELD};

  // register map, one register per address
  localparam logic [3:0] REG_SEL0    = 4'h0;
  localparam logic [3:0] REG_SEL7    = 4'h7;
  localparam logic [3:0] REG_STATUS  = 4'h8;
  localparam logic [3:0] REG_MASK    = 4'h9;
  localparam logic [3:0] REG_CTRL    = 4'hA;
  localparam logic [3:0] REG_PATTERN = 4'hB;

  // interrupt event bits
  localparam int EV_LOCK_LOST = 6;
  localparam int EV_PAT_CHG   = 7;

endpackage

// file: rtl/vsfs_sync.sv
// two flip-flop synchroniser for one pin level
// assumes the pin is asynchronous to i_mclk
`timescale 1ns/1ps
module vsfs_sync (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);

  typedef struct packed {
    logic meta;
    logic sync;
  } vsfs_sync_t;

  vsfs_sync_t s;
  vsfs_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s      = s;
    next_s.meta = i_async;
    next_s.sync = s.meta;
    if (i_reset) begin
      next_s = '0;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  assign o_sync = s.sync;

endmodule // vsfs_sync

// file: rtl/vsfs_top.sv
// multi-function i/o pin select for a serial video serializer
// assumes status inputs come from logic on i_mclk; pins are asynchronous
`timescale 1ns/1ps
module vsfs_top (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  input  wire logic       i_fifo_full_flag_error,
  input  wire logic       i_packet_flag_error,
  input  wire logic       i_anc_flag_error,
  input  wire logic       i_edh_error,
  input  wire logic       i_sav,
  input  wire logic       i_eav,
  input  wire logic       i_protection_bit_flag,
  input  wire logic       i_field,
  input  wire logic       i_vblank,
  input  wire logic       i_hblank,
  input  wire logic [4:0] i_format,
  input  wire logic       i_fifo_full,
  input  wire logic       i_fifo_empty,
  input  wire logic       i_lock_detect,
  input  wire logic       i_pass_fail,
  input  wire logic       i_fifo_overrun,
  input  wire logic       i_anc_checksum_error,
  input  wire logic       i_self_test,
  input  wire logic [7:0] i_io_pin,
  output logic      [7:0] o_io_out,
  output logic      [7:0] o_io_oe,
  output logic            o_force_error_check_words,
  output logic            o_edh_enable,
  output logic            o_pattern_generator_enable,
  output logic            o_checksum_attach,
  output logic            o_pattern_filter_enable,
  output logic            o_dither_enable,
  output logic            o_fifo_insert_enable,
  output logic      [5:0] o_pattern_select,
  output logic      [5:0] o_active_pattern,
  output logic            o_hd,
  output logic            o_sd_pal,
  output logic      [1:0] o_sd_rate,
  output logic      [1:0] o_sd_pattern,
  output logic            o_rate_invalid
);

  typedef struct packed {
    logic [7:0][5:0] sel;
    logic [7:0]      status;
    logic [7:0]      mask;
    logic [7:0]      rdata;
    logic [7:0]      io_out;
    logic [7:0]      io_oe;
    logic [15:0]     ctrl;
    logic [5:0]      active;
    logic            hd;
    logic            sd_pal;
    logic [1:0]      sd_rate;
    logic [1:0]      sd_pattern;
    logic            rate_invalid;
    logic [6:0]      prev_lvl;
    logic [5:0]      prev_word;
    logic            irq;
  } vsfs_state_t;

  vsfs_state_t s;
  vsfs_state_t next_s;
  logic [7:0]  pin_sync;
  logic [31:0] stat_vec;
  logic [15:0] in_vec;
  logic [5:0]  word;
  logic [7:0]  ev_lvl;
  logic [7:0]  ev_set;

  // code names a real output function
  function automatic logic is_out(input logic [5:0] code);
    return !code[5] && vsfs_pkg::OUT_VALID[code[4:0]];
  endfunction

  // code names a real input function
  function automatic logic is_in(input logic [5:0] code);
    return code[5] && !code[4] && vsfs_pkg::IN_VALID[code[3:0]];
  endfunction

  // every pin passes two flops before use
  genvar gi;
  generate
    for (gi = 0; gi < vsfs_pkg::NUM_PINS; gi++) begin : g_pin
      vsfs_sync u_sync (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_async (i_io_pin[gi]),
        .o_sync  (pin_sync[gi])
      );
    end
  endgenerate

  // status sources indexed by output code
  always_comb begin
    stat_vec        = '0;
    stat_vec[1]     = i_fifo_full_flag_error;
    stat_vec[2]     = i_packet_flag_error;
    stat_vec[3]     = i_anc_flag_error;
    stat_vec[4]     = i_edh_error;
    stat_vec[13]    = i_sav;
    stat_vec[14]    = i_eav;
    stat_vec[15]    = i_protection_bit_flag;
    stat_vec[18]    = i_field;
    stat_vec[19]    = i_vblank;
    stat_vec[20]    = i_hblank;
    stat_vec[25:21] = i_format;
    stat_vec[26]    = i_fifo_full;
    stat_vec[27]    = i_fifo_empty;
    stat_vec[28]    = i_lock_detect;
    stat_vec[29]    = i_pass_fail;
    stat_vec[30]    = i_fifo_overrun;
    stat_vec[31]    = i_anc_checksum_error;
  end

  // input functions gathered from pins; unassigned ones read low
  always_comb begin
    in_vec = '0;
    for (int p = 0; p < vsfs_pkg::NUM_PINS; p++) begin
      if (is_in(s.sel[p])) begin
        in_vec[s.sel[p][3:0]] = in_vec[s.sel[p][3:0]] | pin_sync[p];
      end
    end
    word = in_vec[vsfs_pkg::IN_PAT0 +: vsfs_pkg::CODE_W];
  end

  // interrupt event levels
  always_comb begin
    ev_lvl                        = '0;
    ev_lvl[0]                     = i_fifo_full_flag_error;
    ev_lvl[1]                     = i_packet_flag_error;
    ev_lvl[2]                     = i_anc_flag_error;
    ev_lvl[3]                     = i_edh_error;
    ev_lvl[4]                     = i_fifo_overrun;
    ev_lvl[5]                     = i_anc_checksum_error;
    ev_lvl[vsfs_pkg::EV_LOCK_LOST] = !i_lock_detect;
    ev_set[6:0] = ev_lvl[6:0] & ~s.prev_lvl;
    ev_set[vsfs_pkg::EV_PAT_CHG]  = word != s.prev_word;
  end

  // next state
  always_comb begin
    next_s = s;
    // pin drivers
    for (int p = 0; p < vsfs_pkg::NUM_PINS; p++) begin
      next_s.io_oe[p] = is_out(s.sel[p]);
      // selected status source onto pin, low for non-output codes
      next_s.io_out[p] = is_out(s.sel[p]) && stat_vec[s.sel[p][4:0]];
    end
    next_s.ctrl = in_vec;
    next_s.hd = word[vsfs_pkg::PAT_HD];
    next_s.sd_pal       = !word[vsfs_pkg::PAT_HD] && word[vsfs_pkg::PAT_PAL];
    next_s.sd_rate      = word[vsfs_pkg::PAT_HD] ? 2'h0 : word[3:2];
    next_s.sd_pattern   = word[vsfs_pkg::PAT_HD] ? 2'h0 : word[1:0];
    next_s.rate_invalid = !word[vsfs_pkg::PAT_HD] &&
                          (word[3:2] == vsfs_pkg::RATE_BAD);
    if (!i_self_test) begin
      next_s.active = word;
    end else if (word[vsfs_pkg::PAT_HD]) begin
      next_s.active = {word[5:2], vsfs_pkg::PAT_BARS};
    end else begin
      next_s.active = word[vsfs_pkg::PAT_PAL] ? vsfs_pkg::BIST_PAL_PLL :
                                                vsfs_pkg::BIST_NTSC_BARS;
    end
    // sticky status, set wins over clear
    next_s.prev_lvl  = ev_lvl[6:0];
    next_s.prev_word = word;
    next_s.status    = s.status | ev_set;
    // register writes
    if (i_wr) begin
      if (i_addr <= vsfs_pkg::REG_SEL7) begin
        next_s.sel[i_addr[2:0]] = i_wdata[5:0];
      end else if (i_addr == vsfs_pkg::REG_STATUS) begin
        next_s.status = (s.status & ~i_wdata) | ev_set;
      end else if (i_addr == vsfs_pkg::REG_MASK) begin
        next_s.mask = i_wdata;
      end
    end
    // read data stand for one cycle only
    next_s.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        vsfs_pkg::REG_STATUS:  next_s.rdata = s.status;
        vsfs_pkg::REG_MASK:    next_s.rdata = s.mask;
        vsfs_pkg::REG_CTRL:    next_s.rdata = {s.ctrl[15], s.ctrl[13:12],
                                               s.ctrl[10], s.ctrl[8:7],
                                               s.ctrl[0], s.rate_invalid};
        vsfs_pkg::REG_PATTERN: next_s.rdata = {s.hd, 1'b0, s.active};
        default: begin
          if (i_addr <= vsfs_pkg::REG_SEL7) begin
            next_s.rdata = {2'h0, s.sel[i_addr[2:0]]};
          end
        end
      endcase
    end
    next_s.irq = |(next_s.status & next_s.mask);
    if (i_reset) begin
      next_s     = '0;
      next_s.sel = vsfs_pkg::PIN_DEFAULT;
      // lock starts out lost, so no false lock event after reset
      next_s.prev_lvl[vsfs_pkg::EV_LOCK_LOST] = 1'b1;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  // outputs straight from state
  assign o_rdata                    = s.rdata;
  assign o_irq                      = s.irq;
  assign o_io_out                   = s.io_out;
  assign o_io_oe                    = s.io_oe;
  assign o_force_error_check_words  = s.ctrl[vsfs_pkg::IN_FORCE];
  assign o_edh_enable               = s.ctrl[vsfs_pkg::IN_EDH_EN];
  assign o_pattern_generator_enable = s.ctrl[vsfs_pkg::IN_PGEN];
  assign o_checksum_attach          = s.ctrl[vsfs_pkg::IN_CKSUM];
  assign o_pattern_filter_enable    = s.ctrl[vsfs_pkg::IN_FILTER];
  assign o_dither_enable            = s.ctrl[vsfs_pkg::IN_DITHER];
  assign o_fifo_insert_enable       = s.ctrl[vsfs_pkg::IN_FINS];
  assign o_pattern_select           = s.ctrl[vsfs_pkg::IN_PAT0 +: 6];
  assign o_active_pattern           = s.active;
  assign o_hd                       = s.hd;
  assign o_sd_pal                   = s.sd_pal;
  assign o_sd_rate                  = s.sd_rate;
  assign o_sd_pattern               = s.sd_pattern;
  assign o_rate_invalid             = s.rate_invalid;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  logic pgen_any;
  always_comb begin
    pgen_any = 1'b0;
    for (int p = 0; p < vsfs_pkg::NUM_PINS; p++) begin
      pgen_any = pgen_any | (s.sel[p] == vsfs_pkg::FN_PGEN);
    end
  end

  sequence sd_bist_req;
    i_self_test && !word[5];
  endsequence

  sequence hd_bist_req;
    i_self_test && word[5];
  endsequence

  chk_sd_family_select: assert property (
    !word[5] |=> !o_hd && !o_active_pattern[5])
    else $error("sd word did not clear hd");

  chk_sd_word_decode: assert property (
    !word[5] |=> o_sd_pal == $past(word[4]) && o_sd_rate == $past(word[3:2])
                 && o_sd_pattern == $past(word[1:0]))
    else $error("sd word fields decoded wrong");

  chk_sd_bist_pair: assert property (
    sd_bist_req |=> o_active_pattern == ($past(word[4]) ?
      vsfs_pkg::BIST_PAL_PLL : vsfs_pkg::BIST_NTSC_BARS))
    else $error("sd self-test pattern wrong");

  chk_hd_bist_bars: assert property (
    hd_bist_req |=> o_active_pattern == {$past(word[5:2]), 2'h3})
    else $error("hd self-test not color bars");

  chk_pin_direction: assert property (
    s.sel[0][5] || s.sel[0] == 6'h00 |=> !o_io_oe[0])
    else $error("pin driven on input or reserved code");

  chk_field_on_pin: assert property (
    s.sel[0] == vsfs_pkg::FN_FIELD |=> o_io_oe[0] &&
      o_io_out[0] == $past(i_field)) else $error("field not on pin 0");

  chk_lock_on_pin: assert property (
    s.sel[4] == vsfs_pkg::FN_LOCK |=> o_io_oe[4] &&
      o_io_out[4] == $past(i_lock_detect)) else $error("lock not on pin");

  chk_pgen_unassigned: assert property (
    !pgen_any [*3] |=> !o_pattern_generator_enable)
    else $error("generator enable high with no pin");

  chk_reset_pin_map: assert property (
    disable iff (1'b0) $past(i_reset) |-> s.sel == vsfs_pkg::PIN_DEFAULT
      && o_io_oe == 8'h00) else $error("power-on pin map wrong");

  chk_irq_level: assert property (
    $rose(i_fifo_full_flag_error) && s.mask[0] &&
    !(i_wr && i_addr == vsfs_pkg::REG_MASK) |=> o_irq && s.status[0])
    else $error("fifo flag event lost or no interrupt");

endmodule // vsfs_top

// file: verif/vsfs_host_model.sv
// host-side model of the board logic on the eight multi-function pins
// assumes the device drives a pin only while its enable bit is high
`timescale 1ns/1ps
module vsfs_host_model (
  input  wire logic [7:0] i_io_out,
  input  wire logic [7:0] i_io_oe,
  input  wire logic [7:0] i_drive,
  output logic      [7:0] o_pin
);
  // steady host drive
  // an enabled pin shows the device value and the host keeps off it
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      o_pin[p] = i_io_oe[p] ? i_io_out[p] : i_drive[p];
    end
  end
endmodule // vsfs_host_model

// file: verif/video_serializer_io_function_select_test.sv
// self-checking bench for the pin function select block
// assumes a 40 MHz clock and a host model that drives the input pins
`timescale 1ns/1ps
module video_serializer_io_function_select_test;
  logic       i_mclk, i_reset, i_wr, i_rd, i_self_test;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_io_out, o_io_oe, pin, drv, d;
  logic       o_irq, o_hd, o_sd_pal, o_rate_invalid;
  logic [1:0] o_sd_rate, o_sd_pattern;
  logic [5:0] o_pattern_select, o_active_pattern, w;
  logic [6:0] ctl;
  logic [31:0] st, lfsr;
  logic       ff_e, pk_e, an_e, ed_e, sav, eav, prt, fld, vb, hb;
  logic       ffu, fem, lck, pf, ovr, cks;
  logic [4:0] fmt;
  int         error_cnt, cmp_count, e;
  localparam logic [7:0][5:0] PON = {6'h28, 6'h1D, 6'h04, 6'h1C,
                                     6'h19, 6'h14, 6'h13, 6'h12};
  localparam logic [31:0] OUT_OK = 32'hFFFC_E01E;

  vsfs_top uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_fifo_full_flag_error(ff_e),
    .i_packet_flag_error(pk_e), .i_anc_flag_error(an_e),
    .i_edh_error(ed_e), .i_sav(sav), .i_eav(eav),
    .i_protection_bit_flag(prt), .i_field(fld), .i_vblank(vb),
    .i_hblank(hb), .i_format(fmt), .i_fifo_full(ffu),
    .i_fifo_empty(fem), .i_lock_detect(lck), .i_pass_fail(pf),
    .i_fifo_overrun(ovr), .i_anc_checksum_error(cks),
    .i_self_test(i_self_test), .i_io_pin(pin), .o_io_out(o_io_out),
    .o_io_oe(o_io_oe), .o_force_error_check_words(ctl[0]),
    .o_edh_enable(ctl[1]), .o_pattern_generator_enable(ctl[2]),
    .o_checksum_attach(ctl[3]), .o_pattern_filter_enable(ctl[4]),
    .o_dither_enable(ctl[5]), .o_fifo_insert_enable(ctl[6]),
    .o_pattern_select(o_pattern_select),
    .o_active_pattern(o_active_pattern), .o_hd(o_hd),
    .o_sd_pal(o_sd_pal), .o_sd_rate(o_sd_rate),
    .o_sd_pattern(o_sd_pattern), .o_rate_invalid(o_rate_invalid));

  vsfs_host_model host (.i_io_out(o_io_out), .i_io_oe(o_io_oe),
    .i_drive(drv), .o_pin(pin));

  // free-running clock, 25 ns period
  always #12.5 i_mclk = ~i_mclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  // status levels indexed by their output function code
  task automatic set_st(input logic [31:0] v);
    {ed_e, an_e, pk_e, ff_e} <= v[4:1];
    {prt, eav, sav} <= v[15:13];
    {hb, vb, fld} <= v[20:18];
    fmt <= v[25:21];
    {cks, ovr, pf, lck, fem, ffu} <= v[31:26];
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge i_mclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {i_mclk, i_wr, i_rd, i_self_test, i_addr, i_wdata, drv} = '0;
    {error_cnt, cmp_count} = '0;
    st = '0;
    set_st(st);
    lfsr = 32'ha6bd;
    i_reset = 1'b1;
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    // power-on pin map and drive enables
    for (int p = 0; p < 8; p++) begin
      rd(p[3:0], d);
      chk("pin select", {2'h0, PON[p]}, d);
    end
    settle(2);
    chk("pin enable", 8'h7F, o_io_oe);
    // every code on pin 0 with random status levels
    for (int c = 0; c < 64; c++) begin
      wr(4'h0, c[7:0]);
      lfsr = lfsr_next(lfsr);
      st = lfsr;
      set_st(st);
      settle(3);
      e = (c < 32 && OUT_OK[c]) ? st[c] : 0;
      chk("pin0 out", {7'h0, e[0]}, {7'h0, o_io_out[0]});
      e = (c < 32 && OUT_OK[c]) ? 1 : 0;
      chk("pin0 enable", {7'h0, e[0]}, {7'h0, o_io_oe[0]});
    end
    // every input code on pin 7 held high by the host
    @(posedge i_mclk);
    drv <= 8'h80;
    for (int c = 32; c < 48; c++) begin
      wr(4'h7, c[7:0]);
      settle(6);
      case (c)
        32: e = 1;  39: e = 2;  40: e = 4;  42: e = 8;
        44: e = 16; 45: e = 32; 47: e = 64;
        default: e = 0;
      endcase
      chk("control bits", e[7:0], {1'b0, ctl});
      chk("pin7 enable", 8'h00, {7'h0, o_io_oe[7]});
    end
    wr(4'h7, 8'h28);
    // pattern select word on pins 0..5, with and without self-test
    for (int p = 0; p < 6; p++) wr(p[3:0], 8'h21 + p[7:0]);
    for (int k = 0; k < 24; k++) begin
      lfsr = lfsr_next(lfsr);
      w = (k == 0) ? 6'h0C : lfsr[5:0];
      @(posedge i_mclk);
      drv <= {2'b10, w};
      i_self_test <= lfsr[8];
      settle(6);
      chk("select word", {2'h0, w}, {2'h0, o_pattern_select});
      d = w[5] ? 8'h80 : {2'b00, w}; // hd leaves sd fields at zero
      chk("decode", d, {o_hd, 2'h0, o_sd_pal, o_sd_rate,
                        o_sd_pattern});
      e = (!w[5] && w[3:2] == 2'h3) ? 1 : 0;
      chk("rate flag", {7'h0, e[0]}, {7'h0, o_rate_invalid});
      if (!lfsr[8]) d = {2'h0, w};
      else if (w[5]) d = {2'h0, w[5:2], 2'h3};
      else d = w[4] ? 8'h11 : 8'h03;
      chk("active word", d, {2'h0, o_active_pattern});
    end
    // interrupt: raise, clear by writing one, then masked
    @(posedge i_mclk);
    set_st(32'h0);
    settle(2);
    wr(4'h8, 8'hFF);
    wr(4'h9, 8'h01);
    settle(2);
    chk("irq idle", 8'h00, {7'h0, o_irq});
    @(posedge i_mclk);
    ff_e <= 1'b1;
    settle(2);
    chk("irq raised", 8'h01, {7'h0, o_irq});
    rd(4'h8, d);
    chk("status", 8'h01, d);
    wr(4'h8, 8'h01);
    settle(1);
    chk("irq cleared", 8'h00, {7'h0, o_irq});
    wr(4'h9, 8'h00);
    ff_e <= 1'b0;
    settle(2);
    @(posedge i_mclk);
    ff_e <= 1'b1;
    settle(2);
    chk("irq masked", 8'h00, {7'h0, o_irq});
    rd(4'h8, d);
    chk("status masked", 8'h01, d);
    rd(4'hC, d);
    chk("unmapped read", 8'h00, d);
    give_verdict();
  end
endmodule // video_serializer_io_function_select_test
